// File: rtl/fpcd_host.sv
// Host controller that drives flash command sequences from software orders.
// Notes on behaviour
// - Buffer loads stay within start page.
// - Word count operand is loads minus one.
// - Reset command leaves autoselect or timeout status.
// - Identification read as three separate reads.
// - Buffered sequence never exceeds 37 cycles.
// - Bypass program only inside bypass; exit 90/00.
// - Leave every set with 90 then 00.
// - Password words each programmed with A0 cycle.
// - Unlock: 25, 03, four words, then 29.
// - Acceleration input high while setting bits.
// - Bad sequence recovered with reset F0.
`timescale 1ns/10ps
`include "fpcd_cfg.svh"
module fpcd_host
    import fpcd_pkg::*;
#(
    parameter int AW = 23,
    parameter bit BOOT_MODEL = 1'b0
) (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RESETN,
    // Software command port.
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Flash pins.
    output logic FLASH_CE_N,
    output logic FLASH_WE_N,
    output logic FLASH_OE_N,
    output logic [22:0] FLASH_ADDR,
    output logic [15:0] FLASH_DQ_OUT,
    output logic FLASH_DQ_OE_N,
    input wire logic [15:0] FLASH_DQ_IN,
    output logic FLASH_ACC
);
    // ==========================================================
    // Reset synchroniser
    // ==========================================================
    logic rst_meta_q; // First stage, read only by the second.
    logic rst_n_q; // Released reset used by the whole design.
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    logic [4:0] op_q; // Operation ordered by software.
    logic [7:0] count_q; // Word count or set mode code operand.
    logic [AW-1:0] addr_q; // Target address or sector address.
    logic [15:0] data_q; // Program value.
    logic [15:0] pwd_q [4]; // Password words.
    logic acc_q; // Acceleration input level.
    logic busy_q; // A sequence is running.
    logic err_q; // Last order was refused.
    logic bypass_q; // Device is in unlock-bypass mode.
    logic erasing_q; // A sector erase was started.
    logic suspended_q; // The erase is suspended.
    logic in_set_q; // Device is inside a protection command set.
    logic [15:0] rd_q; // Last read value.
    logic [15:0] id_q [3]; // Identification words.
    logic [7:0] step_q; // Cycle index within the sequence.
    logic [7:0] ridx_q; // Read index for the id/read phase.

    // Field decode of the control write.
    wire ctrl_wr = REG_WR && (REG_ADDR == `FPCD_REG_CTRL);
    wire start = ctrl_wr && REG_WDATA[`FPCD_CTRL_START_BIT];
    wire [4:0] new_op = REG_WDATA[`FPCD_CTRL_OP_LSB +: `FPCD_CTRL_OP_W];
    wire [7:0] new_cnt = REG_WDATA[`FPCD_CTRL_COUNT_LSB +: `FPCD_CTRL_COUNT_W];

    // Orders that the device state forbids are refused up front.
    wire bad_bp = (new_op == OP_BYPASS_PROG) && !bypass_q;
    wire bad_sus = (new_op == OP_SUSPEND) && !(erasing_q && !suspended_q);
    wire bad_res = (new_op == OP_RESUME) && !suspended_q;
    wire bad_wc = (new_op == OP_WBUF) && (new_cnt > `FPCD_WBUF_MAX_WORDS);
    wire refuse = bad_bp || bad_sus || bad_res || bad_wc;

    // Sector field: top bits down to A15, or A12 on boot models.
    localparam int SEC_LSB = BOOT_MODEL ? 12 : 15;
    wire [AW-1:0] sec_addr = {addr_q[AW-1:SEC_LSB], {SEC_LSB{1'b0}}};
    // Buffer load address kept in the start page.
    wire [AW-1:0] wbl_addr = {addr_q[AW-1:5], step_q[4:0] - 5'h3};

    // ==========================================================
    // Sequence table: the address and data of cycle step_q
    // ==========================================================
    fpcd_cyc_s cur;
    logic last_step;
    logic [7:0] code;
    // Unlock and command cycles drive only A11..0 and DQ7..0.
    function automatic fpcd_cyc_s wc8(input logic [11:0] a,
                                       input logic [7:0] d);
        fpcd_cyc_s c;
        c.wr = 1'b1;
        c.addr = {11'h000, a};
        c.data = {8'h00, d};
        return c;
    endfunction
    function automatic fpcd_cyc_s wfull(input logic [AW-1:0] a,
                                         input logic [15:0] d);
        fpcd_cyc_s c;
        c.wr = 1'b1;
        c.addr = 23'(a);
        c.data = d;
        return c;
    endfunction
    function automatic fpcd_cyc_s rd(input logic [AW-1:0] a);
        fpcd_cyc_s c;
        c.wr = 1'b0;
        c.addr = 23'(a);
        c.data = 16'h0000;
        return c;
    endfunction

    always_comb begin
        cur = wc8(`FPCD_A_555, `FPCD_D_RESET);
        last_step = 1'b1;
        code = count_q; // Mode code for set entry.
        case (op_q)
            OP_RESET: begin
                cur = wc8(12'h000, `FPCD_D_RESET);
            end
            OP_PROGRAM, OP_PW_PROGRAM, OP_SET_PROG: begin
                // Inside a set only A0 then address/data.
                if (op_q != OP_PROGRAM) begin
                    last_step = (step_q == 8'd1);
                    cur = (step_q == 8'd0) ? wc8(12'h000, `FPCD_D_PROG)
                                           : wfull(addr_q, data_q);
                end else begin
                    last_step = (step_q == 8'd3);
                    case (step_q)
                        8'd0: cur = wc8(`FPCD_A_555, `FPCD_D_UNLOCK1);
                        8'd1: cur = wc8(`FPCD_A_2AA, `FPCD_D_UNLOCK2);
                        8'd2: cur = wc8(`FPCD_A_555, `FPCD_D_PROG);
                        default: cur = wfull(addr_q, data_q);
                    endcase
                end
            end
            OP_WBUF: begin
                // 2 unlocks, 25, count, count+1 loads, 29.
                last_step = (step_q == count_q + 8'd5);
                if (step_q == 8'd0) begin
                    cur = wc8(`FPCD_A_555, `FPCD_D_UNLOCK1);
                end else if (step_q == 8'd1) begin
                    cur = wc8(`FPCD_A_2AA, `FPCD_D_UNLOCK2);
                end else if (step_q == 8'd2) begin
                    cur = wfull(sec_addr, {8'h00, `FPCD_D_WBUF});
                end else if (step_q == 8'd3) begin
                    cur = wfull(sec_addr, {8'h00, count_q});
                end else if (last_step) begin
                    cur = wfull(sec_addr, {8'h00, `FPCD_D_WBCONF});
                end else begin
                    cur = wfull(wbl_addr, data_q);
                end
            end
            OP_WBUF_ABORT, OP_BYPASS_ENTER, OP_SET_ENTER, OP_AUTOSEL_ID,
            OP_PROT_VERIFY: begin
                // Three-write entry, then reads for OP_AUTOSEL_ID and OP_PROT_VERIFY.
                case (op_q)
                    OP_WBUF_ABORT: code = `FPCD_D_RESET;
                    OP_BYPASS_ENTER: code = `FPCD_D_BYPASS;
                    OP_SET_ENTER: code = count_q;
                    default: code = `FPCD_D_AUTOSEL;
                endcase
                last_step = (op_q == OP_AUTOSEL_ID) ? (step_q == 8'd5)
                          : (op_q == OP_PROT_VERIFY) ? (step_q == 8'd3)
                          : (step_q == 8'd2);
                case (step_q)
                    8'd0: cur = wc8(`FPCD_A_555, `FPCD_D_UNLOCK1);
                    8'd1: cur = wc8(`FPCD_A_2AA, `FPCD_D_UNLOCK2);
                    8'd2: cur = wc8(`FPCD_A_555, code);
                    // Fourth cycle is a read; id takes three reads.
                    default: cur = (op_q == OP_PROT_VERIFY)
                        ? rd(sec_addr | AW'(`FPCD_PROT_VERIFY_OFS))
                        : rd(AW'(step_q == 8'd3 ? 8'h01
                                 : step_q == 8'd4 ? 8'h0e
                                 : 8'h0f));
                endcase
            end
            OP_BYPASS_PROG: begin
                last_step = (step_q == 8'd1);
                cur = (step_q == 8'd0) ? wc8(12'h000, `FPCD_D_PROG)
                                       : wfull(addr_q, data_q);
            end
            OP_BYPASS_EXIT, OP_SET_EXIT: begin
                last_step = (step_q == 8'd1);
                cur = (step_q == 8'd0) ? wc8(12'h000, `FPCD_D_AUTOSEL)
                                       : wc8(12'h000, `FPCD_D_EXIT2);
            end
            OP_SECTOR_ERASE: begin
                last_step = (step_q == 8'd5);
                case (step_q)
                    8'd0, 8'd3: cur = wc8(`FPCD_A_555, `FPCD_D_UNLOCK1);
                    8'd1, 8'd4: cur = wc8(`FPCD_A_2AA, `FPCD_D_UNLOCK2);
                    8'd2: cur = wc8(`FPCD_A_555, `FPCD_D_ERASE);
                    default: cur = wfull(sec_addr, {8'h00, `FPCD_D_SECERASE});
                endcase
            end
            OP_SUSPEND: cur = wc8(12'h000, `FPCD_D_SUSPEND);
            OP_RESUME: cur = wc8(12'h000, `FPCD_D_RESUME);
            OP_PPB_ERASE_ALL: begin
                last_step = (step_q == 8'd1);
                cur = (step_q == 8'd0) ? wc8(12'h000, `FPCD_D_ERASE)
                                       : wc8(12'h000, `FPCD_D_SECERASE);
            end
            OP_PW_UNLOCK: begin
                last_step = (step_q == 8'd6);
                case (step_q)
                    8'd0: cur = wc8(12'h000, `FPCD_D_WBUF);
                    8'd1: cur = wc8(12'h000, `FPCD_D_PWUNLK2);
                    8'd6: cur = wc8(12'h000, `FPCD_D_WBCONF);
                    default: cur = wfull(AW'(step_q - 8'd2),
                                         pwd_q[step_q[1:0] - 2'd2]);
                endcase
            end
            OP_SET_READ, OP_READ: cur = rd(addr_q);
            default: cur = wc8(12'h000, `FPCD_D_RESET);
        endcase
    end

    // ==========================================================
    // Bus cycle engine
    // ==========================================================
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cyc_req_q; // Request pulse, dropped on the same edge as the engine takes it.
    fpcd_bus_cycle u_cycle (
        .clk(CLOCK),
        .rst_n(rst_n_q),
        .req(cyc_req_q),
        .cyc(cur),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .ce_n(FLASH_CE_N),
        .we_n(FLASH_WE_N),
        .oe_n(FLASH_OE_N),
        .addr(FLASH_ADDR),
        .dq_out(FLASH_DQ_OUT),
        .dq_oe_n(FLASH_DQ_OE_N),
        .dq_in(FLASH_DQ_IN)
    );
    // Acceleration pin follows software; held high for bit setting.
    assign FLASH_ACC = acc_q;

    // Sequencer: one bus cycle per step, request dropped on the last.
    always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q <= 1'b0; // Idle in array read after reset.
            cyc_req_q <= 1'b0;
            step_q <= '0;
            op_q <= '0;
            count_q <= '0;
            err_q <= 1'b0;
        end else if (!busy_q && start) begin
            err_q <= refuse;
            busy_q <= !refuse;
            cyc_req_q <= !refuse;
            op_q <= new_op;
            count_q <= new_cnt;
            step_q <= '0;
        end else if (busy_q && cyc_done) begin
            cyc_req_q <= !last_step;
            busy_q <= !last_step;
            step_q <= step_q + 8'd1;
        end else if (busy_q) begin
            cyc_req_q <= 1'b0; // Engine takes the request in one edge.
        end
    end

    // Mode tracking from completed sequences.
    wire fin = busy_q && cyc_done && last_step;
    always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bypass_q <= 1'b0;
            erasing_q <= 1'b0;
            suspended_q <= 1'b0;
            in_set_q <= 1'b0;
        end else if (fin) begin
            case (op_q)
                OP_RESET: begin
                    in_set_q <= 1'b0;
                    bypass_q <= 1'b0;
                end
                OP_BYPASS_ENTER: bypass_q <= 1'b1;
                OP_BYPASS_EXIT: bypass_q <= 1'b0;
                OP_SET_ENTER: in_set_q <= 1'b1;
                OP_SET_EXIT: in_set_q <= 1'b0;
                OP_SECTOR_ERASE: erasing_q <= 1'b1;
                OP_SUSPEND: suspended_q <= 1'b1;
                OP_RESUME: suspended_q <= 1'b0;
                default: in_set_q <= in_set_q;
            endcase
        end else if (!busy_q && ctrl_wr && REG_WDATA[9]) begin
            erasing_q <= 1'b0; // Software reports the erase finished.
            suspended_q <= 1'b0;
        end
    end

    // Read data capture and operand registers.
    always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_q <= '0;
            id_q <= '{default: '0};
            addr_q <= '0;
            data_q <= '0;
            pwd_q <= '{default: '0};
            acc_q <= 1'b0;
        end else begin
            if (busy_q && cyc_done && !cur.wr) begin
                rd_q <= cyc_rdata;
                if (op_q == OP_AUTOSEL_ID && step_q >= 8'd3) begin
                    id_q[step_q[1:0] - 2'd3] <= cyc_rdata;
                end
            end
            if (REG_WR && REG_ADDR == `FPCD_REG_ADDR) addr_q <= AW'(REG_WDATA);
            if (REG_WR && REG_ADDR == `FPCD_REG_DATA) data_q <= REG_WDATA[15:0];
            if (REG_WR && REG_ADDR >= `FPCD_REG_PWD0
                    && REG_ADDR <= `FPCD_REG_PWD3) begin
                pwd_q[REG_ADDR[1:0] - 2'd1] <= REG_WDATA[15:0];
            end
            if (REG_WR && REG_ADDR == `FPCD_REG_ACC) acc_q <= REG_WDATA[0];
        end
    end

    // ==========================================================
    // Read port: data one cycle after the strobe
    // ==========================================================
    wire [31:0] status = {22'h0, rd_q[0] == 1'b0, in_set_q, suspended_q,
                          erasing_q, bypass_q, err_q, 3'h0, busy_q};
    logic [31:0] rsel;
    always_comb begin
        case (REG_ADDR)
            `FPCD_REG_STATUS: rsel = status;
            `FPCD_REG_RDATA: rsel = {16'h0, rd_q};
            `FPCD_REG_CTRL: rsel = {id_q[1], id_q[0]};
            `FPCD_REG_ADDR: rsel = {16'h0, id_q[2]};
            default: rsel = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= REG_RD ? rsel : 32'h0000_0000;
        end
    end
endmodule

// File: rtl/fpcd_cfg.svh
// Constants for the flash protection command host: codes, addresses, timing.
`ifndef FPCD_CFG_SVH
`define FPCD_CFG_SVH
// ==========================================================
// Software register offsets (word index on the command port)
// ==========================================================
`define FPCD_REG_CTRL 4'h0
`define FPCD_REG_ADDR 4'h1
`define FPCD_REG_DATA 4'h2
`define FPCD_REG_STATUS 4'h3
`define FPCD_REG_RDATA 4'h4
`define FPCD_REG_PWD0 4'h5
`define FPCD_REG_PWD1 4'h6
`define FPCD_REG_PWD2 4'h7
`define FPCD_REG_PWD3 4'h8
`define FPCD_REG_ACC 4'h9
// ==========================================================
// Control register fields
// ==========================================================
`define FPCD_CTRL_OP_LSB 0
`define FPCD_CTRL_OP_W 5
`define FPCD_CTRL_START_BIT 8
`define FPCD_CTRL_COUNT_LSB 16
`define FPCD_CTRL_COUNT_W 8
// ==========================================================
// Command cycle addresses and data codes
// ==========================================================
`define FPCD_A_555 12'h555
`define FPCD_A_2AA 12'h2aa
`define FPCD_D_UNLOCK1 8'haa
`define FPCD_D_UNLOCK2 8'h55
`define FPCD_D_RESET 8'hf0
`define FPCD_D_AUTOSEL 8'h90
`define FPCD_D_EXIT2 8'h00
`define FPCD_D_PROG 8'ha0
`define FPCD_D_WBUF 8'h25
`define FPCD_D_WBCONF 8'h29
`define FPCD_D_BYPASS 8'h20
`define FPCD_D_ERASE 8'h80
`define FPCD_D_SECERASE 8'h30
`define FPCD_D_SUSPEND 8'hb0
`define FPCD_D_RESUME 8'h30
`define FPCD_D_PWUNLK2 8'h03
`define FPCD_D_SET_LOCKREG 8'h40
`define FPCD_D_SET_PASSWD 8'h60
`define FPCD_D_SET_PERSIST 8'hc0
`define FPCD_D_SET_FREEZE 8'h50
`define FPCD_D_SET_VOLAT 8'he0
`define FPCD_D_DYB_CLEAR 8'h01
// ==========================================================
// Limits and bus timing
// ==========================================================
`define FPCD_WBUF_MAX_CYCLES 37
`define FPCD_WBUF_MAX_WORDS 8'h1f
`define FPCD_PROT_VERIFY_OFS 8'h02
`define FPCD_CLK_NS 10
`define FPCD_T_WP_NS 35
`define FPCD_T_WP_CYC ((`FPCD_T_WP_NS + `FPCD_CLK_NS - 1) / `FPCD_CLK_NS)
`define FPCD_T_ACC_NS 70
`define FPCD_T_ACC_CYC ((`FPCD_T_ACC_NS + `FPCD_CLK_NS - 1) / `FPCD_CLK_NS)
`endif

// File: rtl/fpcd_pkg.sv
// Types shared by the flash protection command host.
package fpcd_pkg;
    // Operations that software may order.
    typedef enum logic [4:0] {
        OP_RESET, OP_PROGRAM, OP_WBUF, OP_WBUF_ABORT, OP_BYPASS_ENTER,
        OP_BYPASS_PROG, OP_BYPASS_EXIT, OP_SECTOR_ERASE, OP_SUSPEND,
        OP_RESUME, OP_AUTOSEL_ID, OP_PROT_VERIFY, OP_SET_ENTER,
        OP_SET_EXIT, OP_SET_PROG, OP_SET_READ, OP_PPB_ERASE_ALL,
        OP_PW_UNLOCK, OP_PW_PROGRAM, OP_READ
    } fpcd_op_e;
    // One bus cycle toward the flash.
    typedef struct packed {
        logic wr;
        logic [22:0] addr;
        logic [15:0] data;
    } fpcd_cyc_s;
endpackage

// File: rtl/fpcd_bus_cycle.sv
// One asynchronous flash bus cycle, timed from the system clock.
`timescale 1ns/10ps
`include "fpcd_cfg.svh"
module fpcd_bus_cycle
    import fpcd_pkg::*;
#(
    parameter int WP_CYC = `FPCD_T_WP_CYC,
    parameter int ACC_CYC = `FPCD_T_ACC_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Request side.
    input wire logic req,
    input wire fpcd_cyc_s cyc,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins.
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic [22:0] addr,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    input wire logic [15:0] dq_in
);
    // ==========================================================
    // Strobe timing
    // ==========================================================
    localparam int CW = 8;
    logic [CW-1:0] cnt_q; // Cycles left in the active strobe phase.
    logic busy_q; // A cycle is in progress.
    logic wr_q; // The cycle is a write.
    logic last;
    assign last = busy_q && (cnt_q == '0);

    // Done rises on the same edge as the strobes, together with rdata, so that the read data
    // captured at the rise already stand in rdata when the caller looks.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= last;
        end
    end

    // CE# and WE# fall together, so the later fall captures the address
    // and the earlier rise captures the data: both edges coincide.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            wr_q <= 1'b0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            addr <= '0;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            rdata <= '0;
        end else if (req && !busy_q) begin
            busy_q <= 1'b1;
            wr_q <= cyc.wr;
            cnt_q <= cyc.wr ? CW'(WP_CYC - 1) : CW'(ACC_CYC - 1);
            addr <= cyc.addr; // Address changes on the same edge as the fall and stands through it.
            dq_out <= cyc.data;
            dq_oe_n <= !cyc.wr; // Drive data only on writes.
            ce_n <= 1'b0;
            we_n <= !cyc.wr;
            oe_n <= cyc.wr;
        end else if (last) begin
            // Rising strobes end the cycle; address and data held until the next request.
            busy_q <= 1'b0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_q) begin
                rdata <= dq_in;
            end
        end else if (busy_q) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// File: test/fpcd_host_properties.sv
// Port checker for the flash protection command host.
`timescale 1ns/10ps
`include "fpcd_cfg.svh"
module fpcd_host_check (
    // Clock, reset and software port.
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    // Flash pins.
    input wire logic FLASH_CE_N,
    input wire logic FLASH_WE_N,
    input wire logic FLASH_OE_N,
    input wire logic FLASH_DQ_OE_N,
    input wire logic FLASH_ACC,
    input wire logic [22:0] FLASH_ADDR,
    input wire logic [15:0] FLASH_DQ_OUT
);
    // ==========================================================
    // Timing of the flash strobes and the read slot
    // ==========================================================
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // A write strobe lasts exactly the four-clock pulse the host promised.
    a_we_pulse: assert property ($fell(FLASH_WE_N) |->
        !FLASH_WE_N [*4] ##1 FLASH_WE_N) else $error("write pulse width");
    a_oe_pulse: assert property ($fell(FLASH_OE_N) |->
        !FLASH_OE_N [*7] ##1 FLASH_OE_N) else $error("read pulse width");
    // Address and data must not move while the device may latch them.
    a_wr_hold: assert property ((!FLASH_WE_N && !$fell(FLASH_WE_N)) |->
        $stable(FLASH_ADDR) && $stable(FLASH_DQ_OUT)) else $error("moved");
    a_bus_release: assert property (!FLASH_OE_N |-> FLASH_DQ_OE_N)
        else $error("host drives data during a read");
    a_strobe_excl: assert property (!(!FLASH_WE_N && !FLASH_OE_N))
        else $error("both strobes low");
    a_ce_frame: assert property ((!FLASH_WE_N || !FLASH_OE_N) |->
        !FLASH_CE_N) else $error("strobe without chip select");
    a_acc_level: assert property ((REG_WR && REG_ADDR == `FPCD_REG_ACC) |=>
        FLASH_ACC == $past(REG_WDATA[0])) else $error("acc level");
    a_rdata_quiet: assert property (!$past(REG_RD) |->
        REG_RDATA == 32'h0) else $error("read data outside slot");
endmodule
bind fpcd_host fpcd_host_check u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FLASH_CE_N(FLASH_CE_N),
    .FLASH_WE_N(FLASH_WE_N), .FLASH_OE_N(FLASH_OE_N), .FLASH_ACC(FLASH_ACC),
    .FLASH_DQ_OE_N(FLASH_DQ_OE_N), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_DQ_OUT(FLASH_DQ_OUT));

// File: test/fpcd_flash_model.sv
// Behavioural flash device answering the host's bus cycles.
`timescale 1ns/10ps
module fpcd_flash_model (
    // Flash pins seen from the device.
    input wire logic ce_n, we_n, oe_n,
    input wire logic [22:0] addr,
    input wire logic [15:0] dq,
    output logic [15:0] q
);
    logic [22:0] a; // Address caught at the later falling strobe.
    logic [7:0] mode = 8'h00; // Set in force; zero means array read.
    logic [1:0] ulk = 2'h0; // Unlock writes seen so far.
    logic armed = 1'b0; // Program code seen on the previous write.
    logic [255:0] dynamic_protect_bit = '0; // Dynamic protect bits, one per sector.
    int nwr = 0; // Write cycles taken, read by the bench.
    wire wr_n = ce_n | we_n;
    wire [7:0] d = dq[7:0];
    initial q = 16'h0;
    always @(negedge wr_n) a = addr;
    // Only the low byte decodes, so stray high bits cannot confuse it.
    always @(posedge wr_n) begin
        nwr++;
        if (d == 8'hf0) mode = 8'h00;
        else if (ulk == 2 && a[11:0] == 12'h555) mode = d;
        else if (mode != 0 && d == 8'h90) mode = 8'hff;
        else if (mode == 8'hff) mode = 8'h00;
        else if (armed && mode == 8'he0) dynamic_protect_bit[a[22:15]] = ~d[0];
        armed = (d == 8'ha0);
        ulk = (a[11:0] == 12'h555 && d == 8'haa) ? 2'h1 :
            (ulk == 1 && a[11:0] == 12'h2aa && d == 8'h55) ? 2'h2 : 2'h0;
    end
    // A released bus shows the inverse of its last value, never stale data.
    always @(negedge oe_n or posedge oe_n) begin
        if (oe_n) q = ~q;
        else if (mode == 8'he0) q = {15'h0, ~dynamic_protect_bit[addr[22:15]]};
        else if (mode == 8'h90) q = {15'h0, dynamic_protect_bit[addr[22:15]]};
        else q = addr[15:0];
    end
endmodule

// File: test/tb_fpcd_host.sv
// Self-checking bench for the flash protection command host.
`timescale 1ns/10ps
`include "fpcd_cfg.svh"
module tb_fpcd_host;
    import fpcd_pkg::*;
    logic CLOCK = 0, RESETN = 0, REG_WR = 0, REG_RD = 0;
    logic [3:0] REG_ADDR = 4'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, v;
    logic ce_n, we_n, oe_n, dq_oe_n, acc;
    logic [22:0] fa;
    logic [15:0] dq_o, dq_i;
    int n_fail = 0, checked = 0, cyc = 0, n;
    fpcd_host DUT (.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .FLASH_CE_N(ce_n), .FLASH_WE_N(we_n),
        .FLASH_OE_N(oe_n), .FLASH_ADDR(fa), .FLASH_DQ_OUT(dq_o),
        .FLASH_DQ_OE_N(dq_oe_n), .FLASH_DQ_IN(dq_i), .FLASH_ACC(acc));
    fpcd_flash_model FLASH (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .addr(fa), .dq(dq_o), .q(dq_i));
    initial forever #5 CLOCK = ~CLOCK;
    // ==========================================================
    // Bus and compare tasks
    // ==========================================================
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: want %h got %h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge CLOCK);
        REG_ADDR <= a; REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1 v = REG_RDATA;
    endtask
    // Start an operation, then poll busy under a bound.
    task automatic op(input fpcd_op_e o, input logic [7:0] c);
        int i;
        wr(`FPCD_REG_CTRL, {8'h0, c, 7'h0, 1'b1, 3'h0, o});
        for (i = 0; i < 300; i++) begin
            rd(`FPCD_REG_STATUS);
            if (v[0] === 1'b0) break;
        end
        chk(32'h0, {31'h0, v[0]});
    endtask
    // Write one dynamic bit of sector 3, read its status back.
    task automatic t_dyb(input logic val);
        wr(`FPCD_REG_DATA, {31'h0, val});
        op(OP_SET_PROG, 8'h0);
        chk(32'h3, {24'h0, FLASH.a[22:15]});
        op(OP_SET_READ, 8'h0);
        rd(`FPCD_REG_RDATA);
        chk({31'h0, val}, {31'h0, v[0]});
    endtask
    task automatic t_protect;
        wr(`FPCD_REG_ACC, 32'h1);
        chk(32'h1, {31'h0, acc});
        op(OP_SET_ENTER, 8'he0);
        chk(32'he0, {24'h0, FLASH.mode});
        wr(`FPCD_REG_ADDR, 32'h18000);
        t_dyb(1'b0);
        t_dyb(1'b1);
        t_dyb(1'b0);
        op(OP_SET_EXIT, 8'h0);
        chk(32'h0, {24'h0, FLASH.mode});
        op(OP_PROT_VERIFY, 8'h0);
        rd(`FPCD_REG_RDATA);
        chk(32'h1, {24'h0, v[7:0]});
        op(OP_RESET, 8'h0);
        chk(32'h0, {24'h0, FLASH.mode});
    endtask
    // A bypass program outside bypass must touch nothing on the flash.
    task automatic t_refuse;
        n = FLASH.nwr;
        op(OP_BYPASS_PROG, 8'h0);
        rd(`FPCD_REG_STATUS);
        chk(32'h1, {31'h0, v[4]});
        chk(n, FLASH.nwr);
    endtask
    task automatic complete_run;
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            complete_run;
        end
    end
    initial begin
        repeat (20) @(posedge CLOCK);
        chk(32'hf, {28'h0, ce_n, we_n, oe_n, dq_oe_n});
        RESETN <= 1'b1;
        repeat (3) @(posedge CLOCK);
        t_protect;
        t_refuse;
        complete_run;
    end
endmodule
